/* logic/charge_gauge_pkg.sv */
// shared offsets, field positions and reset values of the charge gauge register bank
package charge_gauge_pkg;
  localparam logic [3:0] STATE_FLAGS_OFS     = 4'h0;
  localparam logic [3:0] COUNT_BYTE3_OFS     = 4'h1;
  localparam logic [3:0] COUNT_BYTE2_OFS     = 4'h2;
  localparam logic [3:0] COUNT_BYTE1_OFS     = 4'h3;
  localparam logic [3:0] COUNT_BYTE0_OFS     = 4'h4;
  localparam logic [3:0] STORAGE_VOLT_OFS    = 4'h5;
  localparam logic [3:0] END_CHARGE_VOLT_OFS = 4'h6;
  localparam logic [3:0] PROFILE_UPPER_OFS   = 4'h7;
  localparam logic [3:0] MODE_COMMAND_OFS    = 4'h8;
  localparam logic [3:0] VOLTAGE_SET_OFS     = 4'h9;
  localparam logic [3:0] CURRENT_SET_OFS     = 4'ha;
  localparam logic [3:0] WARNING_SET_OFS     = 4'hb;
  localparam logic [3:0] STORAGE_LIMIT_OFS   = 4'hc;
  localparam logic [3:0] OPT_MARGIN_OFS      = 4'hd;

  localparam int LOW_BAT_BIT    = 7;
  localparam int EARLY_WARN_BIT = 6;
  localparam int OUT_ALARM_BIT  = 5;
  localparam int READY_BIT      = 0;
  localparam int OPT_RESET_BIT  = 3;
  localparam int ICH_LSB        = 5;

  localparam logic [2:0] CONT_ACTIVE_CODE   = 3'h6;
  localparam logic [2:0] CONT_CHARGE_CODE   = 3'h2;
  localparam logic [2:0] DEMAND_ACTIVE_CODE = 3'h1 + 3'h4;
  localparam logic [2:0] DEMAND_CHARGE_CODE = 3'h1;
  localparam logic [2:0] EMERGENCY_ICH      = 3'h4;

  localparam logic [7:0] PROFILE_UPPER_RST  = 8'h00;
  localparam logic [7:0] MODE_COMMAND_RST   = 8'h10;
  localparam logic [7:0] VOLTAGE_SET_RST    = 8'h09;
  localparam logic [7:0] CURRENT_SET_RST    = 8'h80;
  localparam logic [7:0] WARNING_SET_RST    = 8'h00;
  localparam logic [7:0] STORAGE_LIMIT_RST  = 8'h00;
  localparam logic [7:0] OPT_MARGIN_RST     = 8'h00;

  localparam int PRIM_PHASE_NS   = 400;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PRIM_PHASE_CYC  = (PRIM_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_PERIOD_NS  = 1000;
  localparam int CONV_PERIOD_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;

  localparam int NUM_LEVELS = 4;
endpackage

/* logic/level_store.sv */
`timescale 1ns/1ns
// small memory of learned charge-target levels, registered read
module level_store #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     ce,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

/* logic/charge_gauge.sv */
`timescale 1ns/1ns
// fuel gauge counter and host register bank
//
// Function
// - count one per boost conversion cycle only while storage charging runs
// - every counted cycle adds exactly one, regardless of capacitor level
// - accumulator is 32 bits, read as four byte registers
// - accumulator readable any time in standby; host reads only then
// - continuous mode: command bits 6h to 2h clears the accumulator
// - on-demand mode: command bits 5h to 1h clears the accumulator
// - codes 0-3 use fixed 400 ns primary phase; code 4 full period
// - optimizer may alternate among several stored charge-target levels
// - charge current resets to 100, profile index resets to 1
// - writing optimizer reset bit discards learned result of current profile
// - early warning and output alarm clear when next charge cycle starts
module charge_gauge #(
  parameter int COUNT_W = 32,
  parameter int LEVEL_W = 8
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               regWr,
  input  wire logic               regRd,
  input  wire logic [3:0]         regAddr,
  input  wire logic [7:0]         regWrData,
  output logic      [7:0]         regRdData,
  input  wire logic               charging,
  input  wire logic               convCycle,
  input  wire logic               lowBatEvent,
  input  wire logic               earlyWarnEvent,
  input  wire logic               outAlarmEvent,
  input  wire logic               readyIn,
  input  wire logic [4:0]         storageVolt,
  input  wire logic [4:0]         endChargeVolt,
  input  wire logic               levelUpdate,
  input  wire logic [LEVEL_W-1:0] levelIn,
  output logic [LEVEL_W-1:0]      chargeTarget,
  output logic                    primPhase,
  output logic                    optReset,
  output logic [7:0]              modeCommand,
  output logic [7:0]              voltageSettings,
  output logic [7:0]              currentSettings,
  output logic [7:0]              warningSettings,
  output logic [7:0]              storageLimit,
  output logic [7:0]              optMargin
);
  localparam int LA_W = $clog2(charge_gauge_pkg::NUM_LEVELS);

  // synchronised pins
  logic [1:0] chargingS, convS, lowBatS, earlyWarnS, alarmS, readyS;
  logic [4:0] storageS1, storageS2, endS1, endS2;
  logic       convPrev;

  logic [COUNT_W-1:0] count_q, count_d;
  logic [7:0] profileUpper_q, modeCommand_q, voltageSet_q, currentSet_q;
  logic [7:0] warningSet_q, storageLimit_q, optMargin_q;
  logic       lowBat_q, earlyWarn_q, outAlarm_q;
  logic       chargingPrev;
  logic [7:0] rdData_d;
  logic [4:0] phaseCnt_q;
  logic [LA_W-1:0] levelPtr_q;
  logic [LEVEL_W-1:0] levelRd;

  wire convEdge    = convS[1] & ~convPrev;
  wire chargeStart = chargingS[1] & ~chargingPrev;
  wire cmdWrite    = regWr && regAddr == charge_gauge_pkg::MODE_COMMAND_OFS;
  wire [2:0] cmdOld = modeCommand_q[2:0];
  wire [2:0] cmdNew = regWrData[2:0];
  wire contClear   = cmdWrite && cmdOld == charge_gauge_pkg::CONT_ACTIVE_CODE
                     && cmdNew == charge_gauge_pkg::CONT_CHARGE_CODE;
  wire demandClear = cmdWrite && cmdOld == charge_gauge_pkg::DEMAND_ACTIVE_CODE
                     && cmdNew == charge_gauge_pkg::DEMAND_CHARGE_CODE;
  wire countClear  = contClear | demandClear;
  wire countInc    = chargingS[1] & convEdge;
  wire [2:0] ichCode = currentSet_q[charge_gauge_pkg::ICH_LSB +: 3];
  wire emergency   = ichCode == charge_gauge_pkg::EMERGENCY_ICH;
  wire [4:0] phaseLen = emergency ? 5'(charge_gauge_pkg::CONV_PERIOD_CYC)
                                  : 5'(charge_gauge_pkg::PRIM_PHASE_CYC);
  wire optResetReq = cmdWrite && regWrData[charge_gauge_pkg::OPT_RESET_BIT];
  wire [LA_W-1:0] levelAddr = LA_W'(modeCommand_q[7:4]);

  // accumulator next value
  always_comb begin
    count_d = count_q;
    if (countClear) begin
      count_d = '0;
    end else if (countInc) begin
      count_d = count_q + COUNT_W'(1);
    end
  end

  // register read multiplexer, most significant byte at lowest address
  always_comb begin
    rdData_d = 8'h00;
    unique case (regAddr)
      charge_gauge_pkg::STATE_FLAGS_OFS:
        rdData_d = {lowBat_q, earlyWarn_q, outAlarm_q, 4'h0, readyS[1]};
      charge_gauge_pkg::COUNT_BYTE3_OFS:     rdData_d = count_q[31:24];
      charge_gauge_pkg::COUNT_BYTE2_OFS:     rdData_d = count_q[23:16];
      charge_gauge_pkg::COUNT_BYTE1_OFS:     rdData_d = count_q[15:8];
      charge_gauge_pkg::COUNT_BYTE0_OFS:     rdData_d = count_q[7:0];
      charge_gauge_pkg::STORAGE_VOLT_OFS:    rdData_d = {3'h0, storageS2};
      charge_gauge_pkg::END_CHARGE_VOLT_OFS: rdData_d = {3'h0, endS2};
      charge_gauge_pkg::PROFILE_UPPER_OFS:   rdData_d = profileUpper_q;
      charge_gauge_pkg::MODE_COMMAND_OFS:    rdData_d = modeCommand_q;
      charge_gauge_pkg::VOLTAGE_SET_OFS:     rdData_d = voltageSet_q;
      charge_gauge_pkg::CURRENT_SET_OFS:     rdData_d = currentSet_q;
      charge_gauge_pkg::WARNING_SET_OFS:     rdData_d = warningSet_q;
      charge_gauge_pkg::STORAGE_LIMIT_OFS:   rdData_d = storageLimit_q;
      charge_gauge_pkg::OPT_MARGIN_OFS:      rdData_d = optMargin_q;
      default:                               rdData_d = 8'h00;
    endcase
  end

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (ce) begin
      chargingS <= {chargingS[0], charging};
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      convS <= {convS[0], convCycle};
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      lowBatS <= {lowBatS[0], lowBatEvent};
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      earlyWarnS <= {earlyWarnS[0], earlyWarnEvent};
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      alarmS <= {alarmS[0], outAlarmEvent};
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      readyS <= {readyS[0], readyIn};
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      storageS1 <= storageVolt;
      storageS2 <= storageS1;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      endS1 <= endChargeVolt;
      endS2 <= endS1;
    end
  end

  // accumulator and edge history
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q      <= '0;
      convPrev     <= 1'b0;
      chargingPrev <= 1'b0;
    end else if (ce) begin
      count_q      <= count_d;
      convPrev     <= convS[1];
      chargingPrev <= chargingS[1];
    end
  end

  // writable settings
  always_ff @(posedge clk) begin
    if (rst) begin
      profileUpper_q <= charge_gauge_pkg::PROFILE_UPPER_RST;
      modeCommand_q  <= charge_gauge_pkg::MODE_COMMAND_RST;
      voltageSet_q   <= charge_gauge_pkg::VOLTAGE_SET_RST;
      currentSet_q   <= charge_gauge_pkg::CURRENT_SET_RST;
      warningSet_q   <= charge_gauge_pkg::WARNING_SET_RST;
      storageLimit_q <= charge_gauge_pkg::STORAGE_LIMIT_RST;
      optMargin_q    <= charge_gauge_pkg::OPT_MARGIN_RST;
    end else if (ce && regWr) begin
      unique case (regAddr)
        charge_gauge_pkg::PROFILE_UPPER_OFS: profileUpper_q <= {6'h00, regWrData[1:0]};
        charge_gauge_pkg::MODE_COMMAND_OFS:
          modeCommand_q <= {regWrData[7:4], 1'b0, regWrData[2:0]};
        charge_gauge_pkg::VOLTAGE_SET_OFS:   voltageSet_q <= regWrData;
        charge_gauge_pkg::CURRENT_SET_OFS:   currentSet_q <= regWrData;
        charge_gauge_pkg::WARNING_SET_OFS:   warningSet_q <= {regWrData[7], 2'h0, regWrData[4:0]};
        charge_gauge_pkg::STORAGE_LIMIT_OFS: storageLimit_q <= {3'h0, regWrData[4], 4'h0};
        charge_gauge_pkg::OPT_MARGIN_OFS:    optMargin_q <= {6'h00, regWrData[1:0]};
        default: ;
      endcase
    end
  end

  // sticky status flags, event set wins over start-of-charge clear
  always_ff @(posedge clk) begin
    if (rst) begin
      lowBat_q <= 1'b0;
    end else if (ce) begin
      lowBat_q <= lowBat_q | lowBatS[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      earlyWarn_q <= 1'b0;
    end else if (ce) begin
      earlyWarn_q <= earlyWarnS[1] | (earlyWarn_q & ~chargeStart);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outAlarm_q <= 1'b0;
    end else if (ce) begin
      outAlarm_q <= alarmS[1] | (outAlarm_q & ~chargeStart);
    end
  end

  // primary phase timer per counted cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      phaseCnt_q <= 5'h00;
    end else if (ce) begin
      if (countInc) begin
        phaseCnt_q <= phaseLen;
      end else if (phaseCnt_q != 5'h00) begin
        phaseCnt_q <= phaseCnt_q - 5'h01;
      end
    end
  end

  // optimizer reset pulse and level rotation
  always_ff @(posedge clk) begin
    if (rst) begin
      optReset   <= 1'b0;
      levelPtr_q <= '0;
    end else if (ce) begin
      optReset <= optResetReq;
      if (chargeStart) begin
        levelPtr_q <= levelPtr_q + LA_W'(1);
      end
    end
  end

  level_store #(
    .DEPTH (charge_gauge_pkg::NUM_LEVELS),
    .WIDTH (LEVEL_W)
  ) u_levels (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (levelUpdate | optResetReq),
    .wrAddr (optResetReq ? levelAddr : levelPtr_q),
    .wrData (optResetReq ? '0 : levelIn),
    .rdAddr (levelPtr_q),
    .rdData (levelRd)
  );

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (ce && regRd) begin
      regRdData <= rdData_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chargeTarget <= '0;
    end else if (ce) begin
      chargeTarget <= levelRd;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      primPhase <= 1'b0;
    end else if (ce) begin
      primPhase <= countInc | (phaseCnt_q > 5'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      modeCommand <= charge_gauge_pkg::MODE_COMMAND_RST;
    end else if (ce) begin
      modeCommand <= modeCommand_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      voltageSettings <= charge_gauge_pkg::VOLTAGE_SET_RST;
    end else if (ce) begin
      voltageSettings <= voltageSet_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      currentSettings <= charge_gauge_pkg::CURRENT_SET_RST;
    end else if (ce) begin
      currentSettings <= currentSet_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      warningSettings <= charge_gauge_pkg::WARNING_SET_RST;
    end else if (ce) begin
      warningSettings <= warningSet_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      storageLimit <= charge_gauge_pkg::STORAGE_LIMIT_RST;
    end else if (ce) begin
      storageLimit <= storageLimit_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      optMargin <= charge_gauge_pkg::OPT_MARGIN_RST;
    end else if (ce) begin
      optMargin <= optMargin_q;
    end
  end
endmodule

/* sim/charge_gauge_checker.sv */
// port assertions for the charge gauge
`timescale 1ns/1ns
module charge_gauge_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       primPhase,
  input wire logic       optReset,
  input wire logic [7:0] modeCommand,
  input wire logic [7:0] voltageSettings,
  input wire logic [7:0] currentSettings
);
  logic [7:0] phaseCnt_q;
  wire        cmdWr  = ce && regWr && regAddr == charge_gauge_pkg::MODE_COMMAND_OFS;
  wire        optReq = cmdWr && regWrData[charge_gauge_pkg::OPT_RESET_BIT];
  wire        rdReq  = ce && regRd;
  wire        vsetWr = ce && regWr && regAddr == charge_gauge_pkg::VOLTAGE_SET_OFS;
  // length of the current primary phase
  always_ff @(posedge clk) begin
    phaseCnt_q <= (rst || !primPhase) ? 8'h00 : phaseCnt_q + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_opt_pulse: assert property (optReq |=> optReset)
    else $error("optimizer reset pulse missing");
  chk_opt_cause: assert property (optReset |-> $past(optReq))
    else $error("optimizer reset pulse without command");
  chk_reset_values: assert property (disable iff (1'b0) rst [*2] |=>
    modeCommand == 8'h10 && voltageSettings == 8'h09 && currentSettings == 8'h80)
    else $error("settings wrong after reset");
  chk_phase_length: assert property ($fell(primPhase) |-> int'(phaseCnt_q) ==
    ((currentSettings[7:5] == 3'h4) ? 25 : 10))
    else $error("primary phase length wrong");
  chk_unmapped_read: assert property (rdReq && regAddr > 4'hd |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_read_holds: assert property (!rdReq && !$past(rdReq) |=> $stable(regRdData))
    else $error("read data changed without read");
  chk_mode_copy: assert property (cmdWr |=> ##1 modeCommand == ($past(regWrData, 2) & 8'hf7))
    else $error("mode command copy wrong");
  chk_vset_copy: assert property (vsetWr |=> ##1 voltageSettings == $past(regWrData, 2))
    else $error("voltage settings copy wrong");
endmodule
bind charge_gauge charge_gauge_checker charge_gauge_checker_i (.clk(clk), .rst(rst), .ce(ce),
  .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .primPhase(primPhase), .optReset(optReset), .modeCommand(modeCommand),
  .voltageSettings(voltageSettings), .currentSettings(currentSettings));

/* sim/host_model.sv */
// host model on the register strobes
`timescale 1ns/1ns
module host_model (
  input  wire logic       clk,
  input  wire logic       charging,
  input  wire logic [7:0] regRdData,
  output logic            regWr     = 1'b0,
  output logic            regRd     = 1'b0,
  output logic [3:0]      regAddr   = 4'h0,
  output logic [7:0]      regWrData = 8'h00
);
  logic [31:0] total = 32'h0;
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    regWr = wr;
    regRd = !wr;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    xfer(1'b0, a, 8'h00);
    @(negedge clk);
    v = regRdData;
  endtask
  task automatic readCount(output logic [31:0] v);
    logic [7:0] b;
    wait (!charging);
    for (int i = 1; i < 5; i++) begin
      rd(4'(i), b);
      v = {v[23:0], b};
    end
    total += v;
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the charge gauge
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0, rst = 1'b1, charging = 1'b0, conv = 1'b0, lowBat = 1'b0;
  logic        earlyWarn = 1'b0, alarm = 1'b0, ready = 1'b0, levelUpd = 1'b0, ce = 1'b1;
  logic        regWr, regRd;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData, regRdData, rdVal;
  logic [7:0]  target, vsetOut, warnOut, limitOut, marginOut;
  logic [31:0] cnt;
  int          num_errors = 0, n_tests = 0, cycles = 0;
  host_model host_i (.clk(clk), .charging(charging), .regRdData(regRdData), .regWr(regWr),
    .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData));
  charge_gauge charge_gauge_i (.clk(clk), .rst(rst), .ce(ce), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .charging(charging),
    .convCycle(conv), .lowBatEvent(lowBat), .earlyWarnEvent(earlyWarn),
    .outAlarmEvent(alarm), .readyIn(ready), .storageVolt(5'h15), .endChargeVolt(5'h0a),
    .levelUpdate(levelUpd), .levelIn(8'h5a), .chargeTarget(target), .primPhase(), .optReset(),
    .modeCommand(), .voltageSettings(vsetOut), .currentSettings(), .warningSettings(warnOut),
    .storageLimit(limitOut), .optMargin(marginOut));
  initial forever #20 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic charge(input int n);
    charging = 1'b1;
    tick(4);
    repeat (n) begin
      conv = 1'b1;
      tick(2);
      conv = 1'b0;
      tick(28);
    end
    charging = 1'b0;
    tick(6);
  endtask
  task automatic t_reset();
    for (int a = 7; a < 16; a++) begin
      host_i.rd(4'(a), rdVal);
      check(rdVal, a == 8 ? 8'h10 : a == 9 ? 8'h09 : a == 10 ? 8'h80 : 8'h00);
    end
    host_i.readCount(cnt);
    check(cnt, 32'h0);
  endtask
  task automatic t_regs();
    ce = 1'b0;
    host_i.xfer(1'b1, 4'h9, 8'h35);
    ce = 1'b1;
    host_i.rd(4'h9, rdVal);
    check(rdVal, 8'h09);
    host_i.xfer(1'b1, 4'h7, 8'hff);
    host_i.xfer(1'b1, 4'h9, 8'hff);
    host_i.xfer(1'b1, 4'hb, 8'hff);
    host_i.xfer(1'b1, 4'hc, 8'hff);
    host_i.xfer(1'b1, 4'hd, 8'hff);
    host_i.rd(4'h7, rdVal);
    check(rdVal, 8'h03);
    host_i.rd(4'hb, rdVal);
    check(rdVal, 8'h9f);
    check({vsetOut, warnOut, limitOut, marginOut}, 32'hff9f1003);
  endtask
  task automatic t_count();
    host_i.xfer(1'b1, 4'h4, 8'hff);
    charge(5);
    repeat (2) begin
      conv = 1'b1;
      tick(2);
      conv = 1'b0;
      tick(28);
    end
    host_i.readCount(cnt);
    check(cnt, 32'h5);
  endtask
  task automatic t_clear();
    host_i.xfer(1'b1, 4'h8, 8'h12);
    host_i.readCount(cnt);
    check(cnt, 32'h5);
    host_i.xfer(1'b1, 4'h8, 8'h16);
    host_i.xfer(1'b1, 4'h8, 8'h12);
    host_i.readCount(cnt);
    check(cnt, 32'h0);
    host_i.xfer(1'b1, 4'ha, 8'h00);
    charge(3);
    host_i.readCount(cnt);
    check(cnt, 32'h3);
    host_i.xfer(1'b1, 4'h8, 8'h15);
    host_i.xfer(1'b1, 4'h8, 8'h11);
    host_i.readCount(cnt);
    check(cnt, 32'h0);
    check(host_i.total, 32'hd);
  endtask
  task automatic t_flags();
    {lowBat, earlyWarn, alarm, ready} = 4'hf;
    tick(4);
    {lowBat, earlyWarn, alarm} = 3'h0;
    tick(4);
    host_i.rd(4'h0, rdVal);
    check(rdVal, 8'he1);
    host_i.rd(4'h5, rdVal);
    check(rdVal, 8'h15);
    host_i.rd(4'h6, rdVal);
    check(rdVal, 8'h0a);
    charge(0);
    host_i.rd(4'h0, rdVal);
    check(rdVal, 8'h81);
  endtask
  task automatic t_opt();
    levelUpd = 1'b1;
    tick(1);
    levelUpd = 1'b0;
    tick(2);
    check(target, 8'h5a);
    host_i.xfer(1'b1, 4'h8, 8'h30);
    host_i.xfer(1'b1, 4'h8, 8'h38);
    host_i.rd(4'h8, rdVal);
    check(rdVal, 8'h30);
    check(target, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_count();
    t_clear();
    t_flags();
    t_opt();
    give_verdict();
  end
endmodule
